// *** src/pscc_led_mux.sv ***
/*
  Port LED selector: maps link status onto four LEDs by the two-bit mode.
  Assumes synchronous status inputs; outputs are registered.
*/
`timescale 1ns/1ps
module pscc_led_mux
  import pscc_pkg::*;
(
  input  wire logic       pclk,        // Clock.
  input  wire logic       presetn,     // Asynchronous reset, active low.
  input  wire logic [1:0] led_mode,    // Upper and lower mode bits.
  input  wire logic       link_up,     // Link is up.
  input  wire logic       activity,    // Traffic seen.
  input  wire logic       full_duplex, // Full duplex link.
  input  wire logic       collision,   // Collision seen.
  input  wire logic       speed_100,   // 100M link.
  output logic      [3:0] port_led     // LED drive, bit n is LED n.
);

  logic [3:0] led_next;

  // Choose what each LED shows for the current mode.
  always_comb begin
    led_next = 4'h0;
    unique case (led_mode)
      2'b00: begin
        led_next = {1'b0, link_up & ~activity | link_up & activity, full_duplex | collision, speed_100};
      end
      2'b01: begin
        led_next = {1'b0, link_up & speed_100, link_up & ~speed_100, full_duplex};
      end
      2'b10: begin
        led_next = {activity, link_up, full_duplex | collision, speed_100};
      end
      2'b11: begin
        led_next = 4'h0;
      end
    endcase
  end

  // Register the LED drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_led <= 4'h0;
    end else begin
      port_led <= led_next;
    end
  end

  led_mode2_a: assert property (@(posedge pclk) disable iff (!presetn)
    led_mode == 2'b10 |=> port_led[3] == $past(activity)) else $error("LED3 does not follow activity.");

endmodule : pscc_led_mux

// *** src/pscc_pkg.sv ***
/*
  Package for the power state and chip control register bank: register byte
  addresses, field positions, reset values and power state codes.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package pscc_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  // Printed offsets 0x00 to 0x10 are not all multiples of four, so they are indices.
  localparam logic [7:0] IDX_CHIP_IDENTITY_AND_RUN  = 8'h00;
  localparam logic [7:0] IDX_GLOBAL_LED_CONTROL     = 8'h0a;
  localparam logic [7:0] IDX_POWER_MANAGEMENT_STATE = 8'h08;
  localparam logic [7:0] IDX_LINK_STATUS            = 8'h10;
  localparam logic [11:0] ADDR_CHIP_IDENTITY_AND_RUN  = {2'b00, IDX_CHIP_IDENTITY_AND_RUN, 2'b00};
  localparam logic [11:0] ADDR_GLOBAL_LED_CONTROL     = {2'b00, IDX_GLOBAL_LED_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_POWER_MANAGEMENT_STATE = {2'b00, IDX_POWER_MANAGEMENT_STATE, 2'b00};
  localparam logic [11:0] ADDR_LINK_STATUS            = {2'b00, IDX_LINK_STATUS, 2'b00};

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FAMILY_LSB     = 8;
  localparam int CHIPCODE_LSB   = 4;
  localparam int REVISION_LSB   = 1;
  localparam int START_BIT      = 0;
  localparam int LED_UPPER_BIT  = 15;
  localparam int LED_LOWER_BIT  = 9;
  localparam int SKIP_RESET_BIT = 3;
  localparam int PME_ENABLE_BIT = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] GLOBAL_LED_CONTROL_RST = 16'h0835;
  localparam logic [15:0] GLOBAL_LED_WRITE_MASK  = 16'h8200;

  // ************************************************************
  // Power state codes
  // ************************************************************
  typedef enum logic [1:0] {
    PSCC_D0    = 2'b00,
    PSCC_D1    = 2'b01,
    PSCC_D2    = 2'b10,
    PSCC_D3HOT = 2'b11
  } pscc_pstate_t;

endpackage : pscc_pkg

// *** src/pscc_regs.sv ***
/*
  Power state and chip control register bank with an APB slave port.
  Assumes a single clock, synchronous inputs and a serial memory loader
  that presents the skip-reset flag with a load strobe.
*/
// Overview of operation
// - Flag clear: software D3hot to D0 pulses an internal reset clearing configuration.
// - Bus reset out of D3hot always leaves device uninitialised; PME enable kept.
// - Skip-reset flag is loaded from serial memory, never written by host.
// - Two-bit power state field, reset zero, written and read back.
// - Identity register shows family, chip and revision codes read only.
// - Bit 0 starts or stops the chip; reset zero.
// - LED mode bits 15 and 9 select what the four LEDs show.
// - Flag set: software D3hot to D0 keeps all configuration.
`timescale 1ns/1ps
module pscc_regs
  import pscc_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE   = 8'h5a, // Arbitrary value.
  parameter logic [3:0] CHIP_CODE     = 4'h3,  // Arbitrary value.
  parameter logic [2:0] REVISION_CODE = 3'h2   // Arbitrary value.
)(
  input  wire logic        pclk,           // APB clock.
  input  wire logic        presetn,        // APB reset, active low.
  input  wire logic        psel,           // Slave select.
  input  wire logic        penable,        // Access phase.
  input  wire logic        pwrite,         // Write when high.
  input  wire logic [11:0] paddr,          // Byte address.
  input  wire logic [31:0] pwdata,         // Write data.
  input  wire logic [3:0]  pstrb,          // Byte strobes.
  output logic      [31:0] prdata,         // Read data.
  output logic             pready,         // Transfer done.
  output logic             pslverr,        // Unmapped address.
  input  wire logic        bus_reset,      // System or bus segment reset, one-cycle pulse.
  input  wire logic        eeprom_load,    // Serial memory load strobe.
  input  wire logic        eeprom_skip_reset_flag, // Skip-reset bit from serial memory.
  input  wire logic        link_up,        // Link is up.
  input  wire logic        activity,       // Traffic seen.
  input  wire logic        full_duplex,    // Full duplex link.
  input  wire logic        collision,      // Collision seen.
  input  wire logic        speed_100,      // 100M link.
  output logic             chip_run,       // Chip operation enabled.
  output logic      [1:0]  power_state,    // Current power state.
  output logic             soft_reset,     // Internal reset pulse.
  output logic             initialised,    // Device counts as initialised.
  output logic      [3:0]  port_led        // LED drive.
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic         chip_run_reg;
  logic [15:0]  gctl_reg;
  pscc_pstate_t pstate_reg;
  logic         skip_reset_reg;
  logic         pme_enable_reg;
  logic         soft_reset_reg;
  logic         init_reg;
  logic [31:0]  rdata_next;
  logic         mapped;
  logic         wr_acc;
  logic         rd_acc;
  logic         sw_wake;
  logic         wr_pm;
  logic [15:0]  gctl_next;

  // APB: one-cycle access phase, zero wait states.
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign mapped = (paddr == ADDR_CHIP_IDENTITY_AND_RUN) || (paddr == ADDR_GLOBAL_LED_CONTROL)
                || (paddr == ADDR_POWER_MANAGEMENT_STATE) || (paddr == ADDR_LINK_STATUS);
  assign wr_pm   = wr_acc & (paddr == ADDR_POWER_MANAGEMENT_STATE) & pstrb[0];
  assign sw_wake = wr_pm & (pstate_reg == PSCC_D3HOT) & (pwdata[1:0] == PSCC_D0);

  // Only the mode bits change; reserved bits keep their reset value.
  assign gctl_next = (gctl_reg & ~GLOBAL_LED_WRITE_MASK) | ({pwdata[15:8] & {8{pstrb[1]}},
                     pwdata[7:0] & {8{pstrb[0]}}} & GLOBAL_LED_WRITE_MASK);

  // ************************************************************
  // Bus answer
  // ************************************************************
  // Ready in the access cycle, error on an unmapped address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // Read data mux, taken in the setup cycle so it stands during access.
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      ADDR_CHIP_IDENTITY_AND_RUN: begin
        rdata_next[15:0] = {FAMILY_CODE, CHIP_CODE, REVISION_CODE, chip_run_reg};
      end
      ADDR_GLOBAL_LED_CONTROL: begin
        rdata_next[15:0] = gctl_reg;
      end
      ADDR_POWER_MANAGEMENT_STATE: begin
        rdata_next[PME_ENABLE_BIT] = pme_enable_reg;
        rdata_next[SKIP_RESET_BIT] = skip_reset_reg;
        rdata_next[1:0]            = pstate_reg;
      end
      ADDR_LINK_STATUS: begin
        rdata_next[4:0] = {speed_100, collision, full_duplex, activity, link_up};
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Hold read data registered for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rdata_next;
    end
  end

  // ************************************************************
  // Power state and reset policy
  // ************************************************************
  // Power state field; bus reset returns it to D0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_reg <= PSCC_D0;
    end else if (bus_reset) begin
      pstate_reg <= PSCC_D0;
    end else if (wr_pm) begin
      pstate_reg <= pscc_pstate_t'(pwdata[1:0]);
    end
  end

  // Skip-reset flag comes only from the serial memory loader.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_reset_reg <= 1'b0;
    end else if (eeprom_load) begin
      skip_reset_reg <= eeprom_skip_reset_flag;
    end
  end

  // PME enable survives soft and bus resets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pme_enable_reg <= 1'b0;
    end else if (wr_pm & pstrb[1]) begin
      pme_enable_reg <= pwdata[PME_ENABLE_BIT];
    end
  end

  // Internal reset pulse on software wake with the flag clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= sw_wake & ~skip_reset_reg;
    end
  end

  // Initialised status: lost by bus reset or soft reset, set by a start write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_reg <= 1'b0;
    end else if (bus_reset | soft_reset_reg) begin
      init_reg <= 1'b0;
    end else if (wr_acc & (paddr == ADDR_CHIP_IDENTITY_AND_RUN) & pstrb[0] & pwdata[START_BIT]) begin
      init_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Start bit; cleared by internal or bus reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_run_reg <= 1'b0;
    end else if (bus_reset | soft_reset_reg) begin
      chip_run_reg <= 1'b0;
    end else if (wr_acc & (paddr == ADDR_CHIP_IDENTITY_AND_RUN) & pstrb[0]) begin
      chip_run_reg <= pwdata[START_BIT];
    end
  end

  // LED mode control; configuration lost on internal or bus reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctl_reg <= GLOBAL_LED_CONTROL_RST;
    end else if (bus_reset | soft_reset_reg) begin
      gctl_reg <= GLOBAL_LED_CONTROL_RST;
    end else if (wr_acc & (paddr == ADDR_GLOBAL_LED_CONTROL)) begin
      gctl_reg <= gctl_next;
    end
  end

  // Outputs from flip-flops.
  assign chip_run    = chip_run_reg;
  assign power_state = pstate_reg;
  assign soft_reset  = soft_reset_reg;
  assign initialised = init_reg;

  // ************************************************************
  // LED selector
  // ************************************************************
  pscc_led_mux u_led (
    .pclk        (pclk),
    .presetn     (presetn),
    .led_mode    ({gctl_reg[LED_UPPER_BIT], gctl_reg[LED_LOWER_BIT]}),
    .link_up     (link_up),
    .activity    (activity),
    .full_duplex (full_duplex),
    .collision   (collision),
    .speed_100   (speed_100),
    .port_led    (port_led)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence wake_write_s;
    sw_wake && !skip_reset_reg && !bus_reset;
  endsequence

  soft_reset_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_write_s |=> soft_reset_reg ##1 (!chip_run_reg && !init_reg && gctl_reg == GLOBAL_LED_CONTROL_RST))
    else $error("Wake without skip flag did not reset configuration.");

  bus_reset_uninit_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_reset |=> !init_reg && pstate_reg == PSCC_D0 && pme_enable_reg == $past(pme_enable_reg))
    else $error("Bus reset left device initialised.");

  skip_flag_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    !eeprom_load |=> $stable(skip_reset_reg))
    else $error("Skip flag changed without a load.");

  pstate_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pm && !bus_reset |=> pstate_reg == $past(pwdata[1:0]))
    else $error("Power state not written.");

  identity_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == ADDR_CHIP_IDENTITY_AND_RUN
    |=> prdata[15:1] == {FAMILY_CODE, CHIP_CODE, REVISION_CODE})
    else $error("Identity fields read wrong.");

  start_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == ADDR_CHIP_IDENTITY_AND_RUN && pstrb[0] && !bus_reset && !soft_reset_reg
    |=> chip_run == $past(pwdata[0]))
    else $error("Start bit not followed.");

  skip_keeps_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    sw_wake && skip_reset_reg |=> !soft_reset_reg ##1 !soft_reset_reg)
    else $error("Wake with skip flag reset the device.");

  reserved_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |-> (gctl_reg & ~GLOBAL_LED_WRITE_MASK) == (GLOBAL_LED_CONTROL_RST & ~GLOBAL_LED_WRITE_MASK))
    else $error("Reserved control bits changed.");

  // Bus answer: ready stands one cycle, unmapped addresses are refused, the upper half reads zero.
  ready_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready stood longer than one cycle.");

  unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pready && pslverr)
    else $error("Unmapped address not refused.");

  upper_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("Upper read half not zero.");

  // Power state word reads back the flag and the current state.
  pm_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == ADDR_POWER_MANAGEMENT_STATE
    |=> prdata[SKIP_RESET_BIT] == $past(skip_reset_reg) && prdata[1:0] == $past(pstate_reg))
    else $error("Power state word read wrong.");

  led_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == ADDR_GLOBAL_LED_CONTROL && pstrb[1] && pstrb[0] && !bus_reset && !soft_reset_reg
    |=> gctl_reg[LED_UPPER_BIT] == $past(pwdata[LED_UPPER_BIT])
        && gctl_reg[LED_LOWER_BIT] == $past(pwdata[LED_LOWER_BIT]))
    else $error("LED mode bits not written.");

  // Resets clear configuration; the internal reset is a single pulse.
  bus_reset_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_reset |=> !chip_run_reg && gctl_reg == GLOBAL_LED_CONTROL_RST)
    else $error("Bus reset kept configuration.");

  soft_reset_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    soft_reset_reg |=> !soft_reset_reg)
    else $error("Internal reset longer than one cycle.");

  init_on_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == ADDR_CHIP_IDENTITY_AND_RUN && pstrb[0] && pwdata[START_BIT]
    && !bus_reset && !soft_reset_reg |=> init_reg)
    else $error("Start write did not initialise.");

  chip_run_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && paddr == ADDR_CHIP_IDENTITY_AND_RUN) && !bus_reset && !soft_reset_reg
    |=> $stable(chip_run_reg))
    else $error("Start bit changed without a write.");

endmodule : pscc_regs

// *** test/pscc_host.sv ***
/*
  Host processor model: an APB master that software tasks drive.
  Assumes a slave that answers with pready; the bench timeout ends a hang.
*/
`timescale 1ns/1ps
module pscc_host (
  input  wire logic        pclk,    // Bus clock.
  output logic             psel,    // Slave select.
  output logic             penable, // Access phase.
  output logic             pwrite,  // Write when high.
  output logic      [11:0] paddr,   // Byte address.
  output logic      [31:0] pwdata,  // Write data.
  output logic      [3:0]  pstrb,   // Byte strobes.
  input  wire logic [31:0] prdata,  // Read data.
  input  wire logic        pready,  // Transfer done.
  input  wire logic        pslverr  // Slave error.
);
  // ************************************************************
  // Bus transfer
  // ************************************************************
  // Idle bus at time zero so the slave never sees an unknown select.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hf;
  end

  // One setup and access phase; request is held until pready is seen high.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d; // Stale data is inverted so nothing leans on it.
  endtask : xfer
endmodule : pscc_host

// *** test/testbench.sv ***
/*
  Self-checking bench for the power state and chip control register bank.
  Assumes the host model drives the APB port; status and loader inputs come from here.
*/
`timescale 1ns/1ps
module testbench;
  import pscc_pkg::*;
  localparam logic [7:0] FAM = 8'h3c; // Arbitrary value.
  localparam logic [3:0] CHP = 4'h6;  // Arbitrary value.
  localparam logic [2:0] REV = 3'h5;  // Arbitrary value.
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [3:0] pstrb, port_led, m;
  logic [1:0] power_state;
  logic e, bus_reset, eeprom_load, flag, link_up, activity, full_duplex, collision, speed_100;
  logic chip_run, soft_reset, initialised;
  int failures, checks_done, cycles, sr_count, sr0;
  logic [7:0] le;

  // ************************************************************
  // Clock, instances and monitors
  // ************************************************************
  always #2.5 pclk = ~pclk;

  pscc_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHP), .REVISION_CODE(REV)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_reset(bus_reset), .eeprom_load(eeprom_load),
    .eeprom_skip_reset_flag(flag), .link_up(link_up), .activity(activity),
    .full_duplex(full_duplex), .collision(collision), .speed_100(speed_100),
    .chip_run(chip_run), .power_state(power_state), .soft_reset(soft_reset),
    .initialised(initialised), .port_led(port_led));

  pscc_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Counts internal reset pulses and cuts a hang short.
  always @(posedge pclk) begin
    if (soft_reset === 1'b1) sr_count++;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    i_host.xfer(1'b1, a, v, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  task automatic load_flag(input logic v);
    @(posedge pclk);
    eeprom_load <= 1'b1;
    flag        <= v;
    @(posedge pclk);
    eeprom_load <= 1'b0;
  endtask : load_flag

  // Expected identity word for a given start bit.
  function automatic logic [31:0] id_exp(input logic run);
    return {16'h0000, FAM, CHP, REV, run};
  endfunction : id_exp

  // Mask of defined LEDs in bits 7:4 and their expected levels in bits 3:0.
  function automatic logic [7:0] led_exp(input logic [1:0] md);
    case (md)
      2'b00:   return {4'b0011, 2'b00, full_duplex | collision, speed_100};
      2'b01:   return {4'b0001, 3'b000, full_duplex};
      2'b10:   return {4'b1111, activity, link_up, full_duplex | collision, speed_100};
      default: return {4'b1111, 4'b0000};
    endcase
  endfunction : led_exp

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {bus_reset, eeprom_load, flag, link_up, activity, full_duplex, collision, speed_100} = 8'h00;
    void'($urandom(99));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CHIP_IDENTITY_AND_RUN, id_exp(1'b0));
    rd(ADDR_GLOBAL_LED_CONTROL, 32'h0000_0835);
    rd(ADDR_POWER_MANAGEMENT_STATE, 32'h0000_0000);
    // Start bit set with every read-only bit written to random values.
    wr(ADDR_CHIP_IDENTITY_AND_RUN, $urandom | 32'h0000_0001);
    rd(ADDR_CHIP_IDENTITY_AND_RUN, id_exp(1'b1));
    chk({31'h0, chip_run}, 32'h0000_0001);
    load_flag(1'b1);
    // Every power state code, flag bit written at random, ending in D3hot.
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_POWER_MANAGEMENT_STATE, ($urandom & 32'hffff_fefc) | s);
      rd(ADDR_POWER_MANAGEMENT_STATE, 32'h0000_0008 | s);
      chk({30'h0, power_state}, s);
    end
    sr0 = sr_count;
    wr(ADDR_POWER_MANAGEMENT_STATE, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(sr_count - sr0, 0);
    chk({31'h0, chip_run}, 32'h0000_0001);
    // All four LED modes, then random modes, with random link status; only defined LEDs are compared.
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      m = (i < 4) ? i[3:0] : {2'b00, d[15], d[9]};
      d[15] = m[1];
      d[9]  = m[0];
      wr(ADDR_GLOBAL_LED_CONTROL, d);
      rd(ADDR_GLOBAL_LED_CONTROL, 32'h0000_0835 | (d & 32'h0000_8200));
      @(posedge pclk);
      {link_up, activity, full_duplex, collision, speed_100} <= 5'($urandom);
      repeat (4) @(posedge pclk);
      le = led_exp(m[1:0]);
      chk({28'h0, port_led & le[7:4]}, {28'h0, le[3:0]});
    end
    // Flag clear: leaving D3hot by software discards configuration.
    wr(ADDR_GLOBAL_LED_CONTROL, 32'h0000_8a35);
    load_flag(1'b0);
    wr(ADDR_POWER_MANAGEMENT_STATE, 32'h0000_0003);
    sr0 = sr_count;
    wr(ADDR_POWER_MANAGEMENT_STATE, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(sr_count - sr0, 1);
    chk({30'h0, chip_run, initialised}, 32'h0000_0000);
    rd(ADDR_GLOBAL_LED_CONTROL, 32'h0000_0835);
    rd(ADDR_CHIP_IDENTITY_AND_RUN, id_exp(1'b0));
    // Bus reset out of D3hot: uninitialised, event enable kept.
    wr(ADDR_CHIP_IDENTITY_AND_RUN, 32'h0000_0001);
    wr(ADDR_POWER_MANAGEMENT_STATE, 32'h0000_0103);
    chk({31'h0, initialised}, 32'h0000_0001);
    @(posedge pclk);
    bus_reset <= 1'b1;
    @(posedge pclk);
    bus_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, initialised}, 32'h0000_0000);
    rd(ADDR_POWER_MANAGEMENT_STATE, 32'h0000_0100);
    // Start bit set and then cleared by software, read-only bits written at random.
    wr(ADDR_CHIP_IDENTITY_AND_RUN, 32'h0000_0001);
    rd(ADDR_CHIP_IDENTITY_AND_RUN, id_exp(1'b1));
    wr(ADDR_CHIP_IDENTITY_AND_RUN, $urandom & 32'hffff_fffe);
    rd(ADDR_CHIP_IDENTITY_AND_RUN, id_exp(1'b0));
    chk({31'h0, chip_run}, 32'h0000_0000);
    // Unmapped address is refused and reads zero.
    i_host.xfer(1'b1, 12'h0fc, $urandom, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    i_host.xfer(1'b0, 12'h0fc, 32'h0000_0000, q, e);
    chk(q, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    end_of_test();
  end
endmodule : testbench
